//--- rtl/nsx_pkg.sv
`default_nettype none
package nsx_pkg;
   // ***********************************************
   // Opcodes
   // ***********************************************
   localparam logic [7:0] OPC_NO_OP     = 8'hff;
   localparam logic [7:0] OPC_OR_WW     = 8'h42;
   localparam logic [7:0] OPC_OR_WI     = 8'h43;
   localparam logic [7:0] OPC_OR_RR     = 8'h44;
   localparam logic [7:0] OPC_OR_RI     = 8'h45;
   localparam logic [7:0] OPC_OR_IMM    = 8'h46;
   localparam logic [7:0] OPC_POP_R     = 8'h50;
   localparam logic [7:0] OPC_POP_I     = 8'h51;
   localparam logic [7:0] OPC_PUSH_R    = 8'h70;
   localparam logic [7:0] OPC_PUSH_I    = 8'h71;
   localparam logic [7:0] OPC_UPOP_DEC  = 8'h92;
   localparam logic [7:0] OPC_UPOP_INC  = 8'h93;
   localparam logic [7:0] OPC_UPUSH_DEC = 8'h82;
   localparam logic [7:0] OPC_UPUSH_INC = 8'h83;
   // ***********************************************
   // Cycle counts and step positions
   // ***********************************************
   localparam logic [3:0] CYC_NO_OP    = 4'h4;
   localparam logic [3:0] CYC_OR_SHORT = 4'h4;
   localparam logic [3:0] CYC_OR_LONG  = 4'h6;
   localparam logic [3:0] CYC_STACK    = 4'h8;
   localparam logic [3:0] STEP_PTR     = 4'h1;
   localparam logic [3:0] STEP_OPND    = 4'h2;
   localparam logic [3:0] STEP_W1      = 4'h6;
   localparam logic [3:0] STEP_W2      = 4'h7;
   // ***********************************************
   // Register map, word indexes
   // ***********************************************
   localparam logic [7:0] WORK_BASE    = 8'hc0;
   localparam logic [9:0] IDX_SSP_HIGH = 10'h0d8;
   localparam logic [9:0] IDX_SSP_LOW  = 10'h0d9;
   localparam logic [9:0] IDX_INSTR    = 10'h100;
   localparam logic [9:0] IDX_CTRL     = 10'h101;
   localparam logic [9:0] IDX_FLAGS    = 10'h102;
   localparam int         CTRL_START   = 0;
   localparam int         STAT_BUSY    = 0;
   localparam int         STAT_BAD     = 1;
   localparam int         FLG_C        = 7;
   localparam int         FLG_Z        = 6;
   localparam int         FLG_S        = 5;
   localparam int         FLG_V        = 4;
   localparam logic [15:0] SSP_RST     = 16'h0000;
   localparam logic [7:0]  FLAGS_RST   = 8'h00;
   localparam logic [23:0] INSTR_RST   = 24'h0000ff;
   typedef enum logic {NSX_IDLE, NSX_RUN} nsx_state_t;
endpackage
`default_nettype wire

//--- rtl/nsx_rf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nsx_rf_if #(
   parameter int AW = 8,
   parameter int DW = 8
);
   logic [AW-1:0] ra;
   logic [AW-1:0] rb;
   logic [AW-1:0] wa;
   logic [DW-1:0] wd;
   logic          we;
   logic [DW-1:0] rda;
   logic [DW-1:0] rdb;
   modport ctrl (output ra, rb, wa, wd, we, input rda, rdb);
   modport mem  (input ra, rb, wa, wd, we, output rda, rdb);
endinterface
`default_nettype wire

//--- rtl/nsx_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module nsx_regfile #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // Clock
   input wire logic clock_i,
   // Storage port
   nsx_rf_if.mem    rf
);
   localparam int DEPTH = 1 << AW;
   logic [DW-1:0] mem_reg [DEPTH];

   always_ff @(posedge clock_i) begin
      if (rf.we) begin
         mem_reg[rf.wa] <= rf.wd;
      end
   end

   assign rf.rda = mem_reg[rf.ra];
   assign rf.rdb = mem_reg[rf.rb];
endmodule
`default_nettype wire

//--- rtl/nsx_or_unit.sv
`timescale 1ns/1ps
`default_nettype none
module nsx_or_unit (
   // Operands
   input  wire logic [7:0] dst_i,
   input  wire logic [7:0] src_i,
   input  wire logic [7:0] flags_i,
   // Results
   output logic      [7:0] result_o,
   output logic      [7:0] flags_o
);
   assign result_o = dst_i | src_i;

   always_comb begin
      flags_o = flags_i;
      flags_o[nsx_pkg::FLG_Z] = (result_o == 8'h00);
      flags_o[nsx_pkg::FLG_S] = result_o[7];
      flags_o[nsx_pkg::FLG_V] = 1'b0;
   end
endmodule
`default_nettype wire

//--- rtl/nsx_exec.sv
// Operation
// - No-operation is one byte, four cycles, and changes nothing.
// - OR stores dst OR src in dst; source stays unchanged.
// - OR: Z on zero result, S copies bit 7, V cleared, others held.
// - OR forms 42 four cycles; 43 to 46 six cycles each.
// - POP reads byte at stack pointer, writes dst, then increments pointer; eight cycles.
// - Decrementing user pop copies pointed byte to dst, then decrements pointer.
// - Incrementing user pop copies pointed byte to dst, then increments pointer.
// - PUSH decrements stack pointer first, then stores source there; eight cycles.
// - Stack pointer is sixteen bits; zero minus one gives all ones.
// - Decrementing user push decrements pointer, then writes source at new address.
// - Incrementing user push increments pointer, then writes source at new address.
// - No-operation, stack and user-stack instructions leave every flag unchanged.
`timescale 1ns/1ps
`default_nettype none
module nsx_exec (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        sys_rst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [11:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Status
   output logic             busy_o
);
   // ***********************************************
   // State
   // ***********************************************
   nsx_pkg::nsx_state_t state_reg;
   logic [3:0]  cyc_reg;
   logic [23:0] instr_reg;
   logic [15:0] ssp_reg;
   logic [15:0] ssp_next;
   logic [7:0]  flags_reg;
   logic [7:0]  flags_next;
   logic [7:0]  ptr_reg;
   logic [7:0]  opa_reg;
   logic [7:0]  opb_reg;
   logic        bad_reg;
   logic        dp_valid_reg;
   logic        dp_write_reg;
   logic [9:0]  dp_idx_reg;
   logic        rd_done_reg;
   logic [31:0] hrdata_reg;

   nsx_rf_if #(.AW(8), .DW(8)) rf_bus ();

   nsx_regfile #(.AW(8), .DW(8)) u_regfile (
      .clock_i (clock_i),
      .rf      (rf_bus.mem)
   );

   // ***********************************************
   // Decode
   // ***********************************************
   wire [7:0] opc     = instr_reg[7:0];
   wire [7:0] b1      = instr_reg[15:8];
   wire [7:0] b2      = instr_reg[23:16];
   wire       run     = (state_reg == nsx_pkg::NSX_RUN);
   wire       is_no_op = (opc == nsx_pkg::OPC_NO_OP);
   wire       is_or   = (opc >= nsx_pkg::OPC_OR_WW) && (opc <= nsx_pkg::OPC_OR_IMM);
   wire       is_pop  = (opc == nsx_pkg::OPC_POP_R) || (opc == nsx_pkg::OPC_POP_I);
   wire       is_push = (opc == nsx_pkg::OPC_PUSH_R) || (opc == nsx_pkg::OPC_PUSH_I);
   wire       is_upop = (opc == nsx_pkg::OPC_UPOP_DEC) || (opc == nsx_pkg::OPC_UPOP_INC);
   wire       is_upsh = (opc == nsx_pkg::OPC_UPUSH_DEC) || (opc == nsx_pkg::OPC_UPUSH_INC);
   wire       known   = is_no_op | is_or | is_pop | is_push | is_upop | is_upsh;
   wire       ind     = (opc == nsx_pkg::OPC_OR_WI) || (opc == nsx_pkg::OPC_OR_RI)
                        || (opc == nsx_pkg::OPC_POP_I) || (opc == nsx_pkg::OPC_PUSH_I)
                        || is_upop || is_upsh;
   wire [7:0] wsrc    = nsx_pkg::WORK_BASE | {4'h0, b1[3:0]};
   wire [7:0] wdst    = nsx_pkg::WORK_BASE | {4'h0, b1[7:4]};
   wire [3:0] ncyc    = is_no_op ? nsx_pkg::CYC_NO_OP
                      : (opc == nsx_pkg::OPC_OR_WW) ? nsx_pkg::CYC_OR_SHORT
                      : is_or ? nsx_pkg::CYC_OR_LONG
                      : nsx_pkg::CYC_STACK;
   wire       last    = run && (cyc_reg == ncyc - 4'h1);
   wire       w1      = run && (cyc_reg == nsx_pkg::STEP_W1);
   wire       w2      = run && (cyc_reg == nsx_pkg::STEP_W2);

   // Indirect forms fetch the pointer register one step before the operand.
   wire [7:0] ptr_src = (opc == nsx_pkg::OPC_OR_WI) ? wsrc : b1;
   wire [7:0] src_adr = (opc == nsx_pkg::OPC_OR_WW) ? wsrc
                      : is_pop ? ssp_reg[7:0]
                      : is_upsh ? b2
                      : ind ? ptr_reg : b1;
   wire [7:0] dst_adr = (opc == nsx_pkg::OPC_OR_RR || opc == nsx_pkg::OPC_OR_RI) ? b2
                      : (opc == nsx_pkg::OPC_OR_IMM) ? b1 : wdst;
   wire [7:0] upd_ptr = opc[0] ? ptr_reg + 8'h01 : ptr_reg - 8'h01;
   wire [7:0] or_src  = (opc == nsx_pkg::OPC_OR_IMM) ? b2 : opa_reg;
   wire [7:0] or_res;
   wire [7:0] or_flags;

   nsx_or_unit u_or (
      .dst_i    (opb_reg),
      .src_i    (or_src),
      .flags_i  (flags_reg),
      .result_o (or_res),
      .flags_o  (or_flags)
   );

   // ***********************************************
   // Execution writes
   // ***********************************************
   // Two write slots keep the documented order of data and pointer updates.
   wire       ex_we = (is_or && last)
                      || (w1 && (is_pop || is_upop || is_upsh))
                      || (w2 && (is_upop || is_upsh || is_push));
   wire [7:0] pop_dst = ind ? ptr_reg : b1;
   wire [7:0] ex_wa = is_or ? dst_adr
                    : w1 ? (is_pop ? pop_dst : is_upop ? b2 : b1)
                    : (is_push ? ssp_reg[7:0] : is_upop ? b1 : upd_ptr);
   wire [7:0] ex_wd = is_or ? or_res
                    : w1 ? (is_upsh ? upd_ptr : opa_reg)
                    : (is_upop ? upd_ptr : opa_reg);

   // ***********************************************
   // AHB-Lite slave
   // ***********************************************
   // Any access that meets a running instruction waits, so software never
   // sees a register file half way through an update.
   wire ap_take  = hsel_i && htrans_i[1] && hready_i;
   wire rd_fetch = dp_valid_reg && !dp_write_reg && !rd_done_reg && !run;
   wire bus_wr   = dp_valid_reg && dp_write_reg && !run;
   wire idx_rf   = (dp_idx_reg[9:8] == 2'b00);
   wire idx_stkh = (dp_idx_reg == nsx_pkg::IDX_SSP_HIGH);
   wire idx_stkl = (dp_idx_reg == nsx_pkg::IDX_SSP_LOW);
   wire wr_stkh  = bus_wr && idx_stkh;
   wire wr_stkl  = bus_wr && idx_stkl;
   wire wr_rf    = bus_wr && idx_rf && !idx_stkh && !idx_stkl;
   wire wr_instr = bus_wr && (dp_idx_reg == nsx_pkg::IDX_INSTR);
   wire wr_flags = bus_wr && (dp_idx_reg == nsx_pkg::IDX_FLAGS);
   wire start_go = bus_wr && (dp_idx_reg == nsx_pkg::IDX_CTRL)
                   && hwdata_i[nsx_pkg::CTRL_START];
   wire [7:0] status = {6'h00, bad_reg, run};
   wire [31:0] rd_mux = idx_stkh ? {24'h000000, ssp_reg[15:8]}
                      : idx_stkl ? {24'h000000, ssp_reg[7:0]}
                      : idx_rf ? {24'h000000, rf_bus.rda}
                      : (dp_idx_reg == nsx_pkg::IDX_INSTR) ? {8'h00, instr_reg}
                      : (dp_idx_reg == nsx_pkg::IDX_CTRL) ? {24'h000000, status}
                      : (dp_idx_reg == nsx_pkg::IDX_FLAGS) ? {24'h000000, flags_reg}
                      : 32'h00000000;

   assign hreadyout_o = !dp_valid_reg || (dp_write_reg ? !run : rd_done_reg);
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_reg;
   assign busy_o      = run;

   assign rf_bus.ra = run ? ((cyc_reg == nsx_pkg::STEP_PTR) ? ptr_src : src_adr)
                          : dp_idx_reg[7:0];
   assign rf_bus.rb = dst_adr;
   assign rf_bus.we = run ? ex_we : wr_rf;
   assign rf_bus.wa = run ? ex_wa : dp_idx_reg[7:0];
   assign rf_bus.wd = run ? ex_wd : hwdata_i[7:0];

   // ***********************************************
   // Stack pointer and flags
   // ***********************************************
   // Only the low byte addresses storage, yet the pointer wraps as one 16-bit value.
   // A push from zero therefore lands at the top of the space, as a user expects.
   assign ssp_next = wr_stkh ? {hwdata_i[7:0], ssp_reg[7:0]}
                   : wr_stkl ? {ssp_reg[15:8], hwdata_i[7:0]}
                   : (w1 && is_push) ? ssp_reg - 16'h0001
                   : (w2 && is_pop) ? ssp_reg + 16'h0001
                   : ssp_reg;
   // Only OR touches the flags; every other instruction here holds them.
   assign flags_next = wr_flags ? hwdata_i[7:0]
                     : (is_or && last) ? or_flags
                     : flags_reg;

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_idx_reg   <= 10'h000;
         rd_done_reg  <= 1'b0;
         hrdata_reg   <= 32'h00000000;
      end else begin
         if (hreadyout_o) begin
            dp_valid_reg <= ap_take;
            dp_write_reg <= hwrite_i;
            dp_idx_reg   <= haddr_i[11:2];
         end
         rd_done_reg <= rd_fetch;
         if (rd_fetch) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg <= nsx_pkg::NSX_IDLE;
         cyc_reg   <= 4'h0;
         instr_reg <= nsx_pkg::INSTR_RST;
         ssp_reg   <= nsx_pkg::SSP_RST;
         flags_reg <= nsx_pkg::FLAGS_RST;
         bad_reg   <= 1'b0;
         ptr_reg   <= 8'h00;
         opa_reg   <= 8'h00;
         opb_reg   <= 8'h00;
      end else begin
         ssp_reg   <= ssp_next;
         flags_reg <= flags_next;
         if (wr_instr) begin
            instr_reg <= hwdata_i[23:0];
         end
         if (start_go) begin
            bad_reg <= !known;
         end
         case (state_reg)
            nsx_pkg::NSX_IDLE: begin
               cyc_reg <= 4'h0;
               if (start_go && known) begin
                  state_reg <= nsx_pkg::NSX_RUN;
               end
            end
            nsx_pkg::NSX_RUN: begin
               cyc_reg <= cyc_reg + 4'h1;
               if (last) begin
                  state_reg <= nsx_pkg::NSX_IDLE;
               end
            end
            default: begin
               state_reg <= nsx_pkg::NSX_IDLE;
            end
         endcase
         if (run && cyc_reg == nsx_pkg::STEP_PTR) begin
            ptr_reg <= rf_bus.rda;
         end
         if (run && cyc_reg == nsx_pkg::STEP_OPND) begin
            opa_reg <= rf_bus.rda;
            opb_reg <= rf_bus.rdb;
         end
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_launch(logic [7:0] o);
      !run && start_go && (opc == o);
   endsequence
   sequence s_ends_after4;
      run[*4] ##1 !run;
   endsequence
   // A user push writes the moved pointer first and the data one cycle later,
   // so the data must land at the address that the pointer write carried.
   sequence s_upush_ptr;
      rf_bus.we && (rf_bus.wa == b1) && (rf_bus.wd == ((opc == nsx_pkg::OPC_UPUSH_INC)
         ? ptr_reg + 8'h01 : ptr_reg - 8'h01));
   endsequence
   sequence s_upush_data;
      rf_bus.we && (rf_bus.wa == $past(rf_bus.wd)) && (rf_bus.wd == opa_reg);
   endsequence

   a_noop_timing: assert property (s_launch(nsx_pkg::OPC_NO_OP) |=> s_ends_after4)
      else $error("no-op length wrong");
   a_noop_quiet: assert property (s_launch(nsx_pkg::OPC_NO_OP) |=>
      (!rf_bus.we && $stable(flags_reg) && $stable(ssp_reg))[*4])
      else $error("no-op changed state");
   a_or_short: assert property (s_launch(nsx_pkg::OPC_OR_WW) |=> s_ends_after4)
      else $error("short or length wrong");
   a_or_long: assert property (s_launch(nsx_pkg::OPC_OR_RI) |=> run[*6] ##1 !run)
      else $error("long or length wrong");
   a_stack_len: assert property (s_launch(nsx_pkg::OPC_POP_I) |=> run[*8] ##1 !run)
      else $error("pop length wrong");
   a_or_flags: assert property ((is_or && last) |=> (flags_reg[nsx_pkg::FLG_V] == 1'b0)
      && (flags_reg[nsx_pkg::FLG_Z] == ($past(opb_reg | or_src) == 8'h00))
      && (flags_reg[nsx_pkg::FLG_C] == $past(flags_reg[nsx_pkg::FLG_C])))
      else $error("or flags wrong");
   a_or_sign: assert property ((is_or && last) |=>
      (flags_reg[nsx_pkg::FLG_S] == $past(opb_reg[7] | or_src[7])))
      else $error("or sign flag wrong");
   a_pop_order: assert property ((is_pop && w1) |-> (rf_bus.we && rf_bus.wd == opa_reg)
      ##1 (ssp_reg == $past(ssp_reg)) ##1 (ssp_reg == $past(ssp_reg, 2) + 16'h0001))
      else $error("pop order wrong");
   a_push_order: assert property ((is_push && w1) |=> (ssp_reg == $past(ssp_reg) - 16'h0001)
      && rf_bus.we && (rf_bus.wa == ssp_reg[7:0]))
      else $error("push order wrong");
   a_user_ptr: assert property ((is_upop && w2) |-> rf_bus.we && (rf_bus.wa == b1)
      && (rf_bus.wd == ((opc == nsx_pkg::OPC_UPOP_INC) ? ptr_reg + 8'h01 : ptr_reg - 8'h01)))
      else $error("user pointer update wrong");
   a_upush_order: assert property ((is_upsh && w1) |->
      s_upush_ptr ##1 s_upush_data)
      else $error("user push order wrong");
   a_flags_held: assert property ((run && !is_or) |=> $stable(flags_reg))
      else $error("flags moved outside or");
endmodule
`default_nettype wire

//--- dv/nsx_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// Shadow of the register file
// ***********************************************
// Holds the bytes that the bench last wrote, so that a source which an
// instruction must leave alone can be compared with what was put there.
module nsx_rf_model;
   logic [7:0] m [0:255];
endmodule
`default_nettype wire

//--- dv/nsx_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_tb;
   // ***********************************************
   // Signals
   // ***********************************************
   logic             clock_i;
   logic             sys_rst_i;
   logic             hsel;
   logic [11:0]      haddr;
   logic [1:0]       htrans;
   logic             hwrite;
   logic [31:0]      hwdata;
   wire logic [31:0] hrdata;
   wire logic        hready;
   wire logic        hresp;
   wire logic        busy;
   int               fail_count;
   int               n_checks;
   logic [31:0]      q;

   nsx_exec i_nsx_exec (
      .clock_i     (clock_i),
      .sys_rst_i   (sys_rst_i),
      .hsel_i      (hsel),
      .haddr_i     (haddr),
      .htrans_i    (htrans),
      .hwrite_i    (hwrite),
      .hsize_i     (3'h2),
      .hwdata_i    (hwdata),
      .hready_i    (hready),
      .hrdata_o    (hrdata),
      .hreadyout_o (hready),
      .hresp_o     (hresp),
      .busy_o      (busy)
   );
   nsx_rf_model i_nsx_rf_model ();

   // ***********************************************
   // Bus and check helpers
   // ***********************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Waits are bounded, so a slave that never answers ends the run.
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         fail_count++;
         $display("mismatch hready expected 1 seen %b", hready);
         report_and_stop();
      end
   endtask

   task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {idx, 2'b00};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask

   task automatic setr(input logic [9:0] idx, input logic [7:0] v);
      xfer(1'b1, idx, {24'h0, v});
      if (idx < 10'h100) begin
         i_nsx_rf_model.m[idx[7:0]] = v;
      end
   endtask

   task automatic getr(input logic [9:0] idx, input logic [7:0] e);
      xfer(1'b0, idx, 32'h0);
      chk($sformatf("word %h", idx), {24'h0, e}, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic run(input logic [23:0] w, input int c);
      int n;
      xfer(1'b1, nsx_pkg::IDX_INSTR, {8'h00, w});
      xfer(1'b1, nsx_pkg::IDX_CTRL, 32'h1);
      n = 0;
      @(posedge clock_i);
      while (busy === 1'b1 && n < 50) begin
         n++;
         @(posedge clock_i);
      end
      if (busy === 1'b1) begin
         fail_count++;
         $display("mismatch busy expected 0 seen %b", busy);
         report_and_stop();
      end
      chk("busy cycles", c, n);
   endtask

   task automatic or1(input logic [23:0] w, input int c, input logic [7:0] d,
                      input logic [7:0] e, input logic [7:0] s, input logic [7:0] f);
      setr(nsx_pkg::IDX_FLAGS, f);
      run(w, c);
      getr({2'b00, d}, e);
      i_nsx_rf_model.m[d] = e;
      getr({2'b00, s}, i_nsx_rf_model.m[s]);
      getr(nsx_pkg::IDX_FLAGS, (f & 8'h8f) | {1'b0, e == 8'h00, e[7], 5'h0});
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_reset();
      getr(10'h0d8, 8'h00);
      getr(10'h0d9, 8'h00);
      getr(nsx_pkg::IDX_FLAGS, 8'h00);
      getr(nsx_pkg::IDX_CTRL, 8'h00);
      setr(10'h3ff, 8'h5a);
      getr(10'h3ff, 8'h00);
      setr(10'h0d8, 8'h12);
      getr(10'h0d8, 8'h12);
      $display("test reset done");
   endtask

   task automatic t_no_op();
      setr(nsx_pkg::IDX_FLAGS, 8'hfc);
      setr(10'h010, 8'h5a);
      run(24'h000001, 0);
      getr(nsx_pkg::IDX_CTRL, 8'h02);
      run(24'h0000ff, 4);
      getr(nsx_pkg::IDX_CTRL, 8'h00);
      getr(nsx_pkg::IDX_FLAGS, 8'hfc);
      getr(10'h010, 8'h5a);
      getr(10'h0d8, 8'h12);
      $display("test no-op done");
   endtask

   task automatic t_or();
      setr(10'h0c0, 8'h15);
      setr(10'h0c1, 8'h2a);
      setr(10'h0c2, 8'h01);
      setr(10'h000, 8'h08);
      setr(10'h001, 8'h37);
      setr(10'h008, 8'h8a);
      or1(24'h000142, 4, 8'hc0, 8'h3f, 8'hc1, 8'h9c);
      setr(10'h0c0, 8'h15);
      or1(24'h000243, 6, 8'hc0, 8'h37, 8'h01, 8'h70);
      or1(24'h000144, 6, 8'h00, 8'h3f, 8'h01, 8'h9c);
      setr(10'h000, 8'h08);
      or1(24'h010045, 6, 8'h01, 8'hbf, 8'h08, 8'h0c);
      or1(24'h020046, 6, 8'h00, 8'h0a, 8'h01, 8'h9c);
      setr(10'h010, 8'h00);
      or1(24'h001046, 6, 8'h10, 8'h00, 8'h01, 8'hac);
      $display("test or done");
   endtask

   task automatic t_stack();
      setr(nsx_pkg::IDX_FLAGS, 8'hfc);
      setr(10'h0d8, 8'h00);
      setr(10'h0d9, 8'hfb);
      setr(10'h0fb, 8'h55);
      run(24'h000050, 8);
      getr(10'h000, 8'h55);
      getr(10'h0d9, 8'hfc);
      setr(10'h0d9, 8'hfb);
      setr(10'h000, 8'h01);
      run(24'h000051, 8);
      getr(10'h001, 8'h55);
      getr(10'h000, 8'h01);
      setr(10'h0d9, 8'h00);
      setr(10'h040, 8'h4f);
      setr(10'h04f, 8'haa);
      run(24'h004070, 8);
      getr(10'h0ff, 8'h4f);
      getr(10'h0d8, 8'hff);
      getr(10'h0d9, 8'hff);
      setr(10'h0d8, 8'h00);
      setr(10'h0d9, 8'h00);
      // The read below is issued while the push runs and must stall.
      xfer(1'b1, nsx_pkg::IDX_INSTR, 32'h004071);
      xfer(1'b1, nsx_pkg::IDX_CTRL, 32'h1);
      getr(10'h0ff, 8'haa);
      getr(10'h0d9, 8'hff);
      getr(nsx_pkg::IDX_FLAGS, 8'hfc);
      $display("test stack done");
   endtask

   task automatic t_user();
      setr(10'h000, 8'h42);
      setr(10'h042, 8'h6f);
      run(24'h020092, 8);
      getr(10'h002, 8'h6f);
      getr(10'h000, 8'h41);
      setr(10'h000, 8'h01);
      setr(10'h001, 8'h70);
      run(24'h020093, 8);
      getr(10'h002, 8'h70);
      getr(10'h000, 8'h02);
      setr(10'h000, 8'h03);
      setr(10'h001, 8'h05);
      run(24'h010082, 8);
      getr(10'h002, 8'h05);
      getr(10'h000, 8'h02);
      setr(10'h000, 8'h03);
      run(24'h010083, 8);
      getr(10'h004, 8'h05);
      getr(10'h000, 8'h04);
      setr(10'h030, 8'h00);
      run(24'h313092, 8);
      getr(10'h031, 8'h04);
      getr(10'h030, 8'hff);
      setr(10'h032, 8'h77);
      run(24'h323083, 8);
      getr(10'h030, 8'h00);
      getr(10'h000, 8'h77);
      getr(nsx_pkg::IDX_FLAGS, 8'hfc);
      $display("test user stack done");
   endtask

   // ***********************************************
   // Clock and main sequence
   // ***********************************************
   initial begin
      clock_i = 1'b0;
      forever begin
         #25 clock_i = ~clock_i;
      end
   end

   initial begin
      sys_rst_i  = 1'b1;
      hsel       = 1'b0;
      haddr      = 12'h000;
      htrans     = 2'b00;
      hwrite     = 1'b0;
      hwdata     = 32'h0;
      fail_count = 0;
      n_checks   = 0;
      repeat (16) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      t_reset();
      t_no_op();
      t_or();
      t_stack();
      t_user();
      report_and_stop();
   end
endmodule
`default_nettype wire
